// ==== design/pll_fabric_interface.v ====
// Fabric-side model of the clock synthesizer: reference select, lock detect,
// three output clocks, APB control and status with one level interrupt.
// Assumes all pins synchronous to pclk and an APB master on pclk.
//
// Contract
// - Pick reference by two-bit select value
// - Held in reset while reset low
// - Lock rises once lock is achieved
// - Lock falls at once on loss
// - Stopped reference keeps lock unchanged
// - Three output clocks for global network
// - External mode uses dedicated reference pin
// - Dynamic mode chooses among four by select
// - Core mode uses one named fabric clock
// - Internal feedback, no phase relation
// - Local feedback aligns output to reference
// - Core feedback aligns, cancels tree delay
//
// Local design decisions: the APB slave port and the register addresses.
`include "synth_map.vh"
module pll_fabric_interface #(
	parameter STALL_CYCLES = `STALL_CYC
) (
	input wire pclk, // System clock
	input wire presetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire pready, // APB ready
	output reg [31:0] prdata, // APB read data
	output reg pslverr, // APB error
	input wire [3:0] ref_clk_in, // Reference clocks
	input wire [1:0] ref_select, // Dynamic reference select
	input wire synth_reset_n, // Synthesizer reset, active low
	input wire fabric_feedback_clk, // Core feedback clock
	input wire external_ref_pin, // Dedicated reference pin
	output wire synth_out_clk_0, // Output clock 0
	output wire synth_out_clk_1, // Output clock 1
	output wire synth_out_clk_2, // Output clock 2
	output reg lock, // Lock indicator
	output wire irq // Level interrupt
);

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	reg [31:0] ctrl_q; // Modes and enables
	reg [31:0] div_q; // Half periods of the outputs
	reg [`INT_W-1:0] int_stat_q; // Sticky events
	reg [`INT_W-1:0] int_mask_q; // Event enables
	reg [7:0] lock_need_q; // Matching periods needed for lock
	reg [1:0] sel_q; // Select latched during reset
	reg [15:0] per_cnt_q; // Cycles since last reference edge
	reg [15:0] last_per_q; // Previous reference period
	reg [7:0] good_q; // Run of matching periods
	reg first_q; // No period measured yet
	reg stalled_q; // Reference stopped toggling
	reg fb_seen_q; // Feedback edge since reference edge
	reg [7:0] fb_dly_q; // Measured tree delay
	reg [7:0] fb_cnt_q; // Cycles since reference edge
	reg [3:0] rst_len_q; // Length of current reset pulse
	reg rst_prev_q; // Reset level last cycle
	reg [1:0] sel_prev_q; // Select last cycle
	reg src_chg_q; // Source moved by last edge's write

	wire [1:0] src_mode = ctrl_q[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
	wire [1:0] fb_mode = ctrl_q[`CTRL_FB_LSB+1:`CTRL_FB_LSB];
	wire [2:0] out_en = ctrl_q[`CTRL_OUT_EN_LSB+2:`CTRL_OUT_EN_LSB];
	wire [1:0] core_ref = ctrl_q[`CTRL_CORE_REF_LSB+1:`CTRL_CORE_REF_LSB];
	wire [1:0] fb_out = ctrl_q[`CTRL_FB_OUT_LSB+1:`CTRL_FB_OUT_LSB];
	wire in_reset = ~synth_reset_n; // Synthesizer held in reset

	// ----------------------------------------
	// Reference source selection
	// ----------------------------------------
	reg ref_level; // Chosen reference level
	always @* begin
		case (src_mode)
			`SRC_EXTERNAL: ref_level = external_ref_pin; // Dedicated pin
			`SRC_DYNAMIC: ref_level = ref_clk_in[sel_q]; // Latched select
			`SRC_CORE: ref_level = ref_clk_in[core_ref]; // One fabric clock
			default: ref_level = 1'b0;
		endcase
	end

	// Select only follows the pin while reset is held, so a live change cannot glitch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= 2'h0;
		end else if (in_reset) begin
			sel_q <= ref_select;
		end
	end

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	wire [1:0] rises; // Bit0 reference, bit1 feedback
	rise_detect #(.W(2)) u_rise (
		.clk(pclk),
		.rst_n(presetn),
		.din({fabric_feedback_clk, ref_level}),
		.rise(rises)
	);
	// Masked for one edge after a source switch, which is no real reference rise
	wire ref_edge = rises[0] & ~src_chg_q;
	wire fb_edge = rises[1];

	// ----------------------------------------
	// Period match and lock
	// ----------------------------------------
	wire [15:0] diff = (per_cnt_q > last_per_q) ? per_cnt_q - last_per_q :
		last_per_q - per_cnt_q;
	wire core_fb = (fb_mode == `FB_CORE);
	wire period_ok = (diff <= 16'h0001) && (!core_fb || fb_seen_q);
	wire stall_now = (per_cnt_q >= STALL_CYCLES[15:0]);
	reg lock_d; // Next lock
	reg [7:0] good_d; // Next run length
	always @* begin
		lock_d = lock;
		good_d = good_q;
		if (ref_edge && !stalled_q && !first_q) begin
			if (period_ok) begin
				good_d = (good_q == 8'hFF) ? good_q : good_q + 8'h01;
				if (good_d >= lock_need_q) begin
					lock_d = 1'b1;
				end
			end else begin
				good_d = 8'h00;
				lock_d = 1'b0; // Loss seen at this edge
			end
		end
	end

	// Measurement state; a stall freezes lock and restarts measuring
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt_q <= 16'h0000;
			last_per_q <= 16'h0000;
			good_q <= 8'h00;
			first_q <= 1'b1;
			stalled_q <= 1'b0;
			lock <= 1'b0;
		end else if (in_reset) begin
			// Lock forced low while reset held
			per_cnt_q <= 16'h0000;
			last_per_q <= 16'h0000;
			good_q <= 8'h00;
			first_q <= 1'b1;
			stalled_q <= 1'b0;
			lock <= 1'b0;
		end else if (ref_edge) begin
			per_cnt_q <= 16'h0001;
			last_per_q <= per_cnt_q;
			// After a stall the old count is stale, so measure one more period
			// before comparing; otherwise a resumed reference drops lock
			first_q <= stalled_q;
			stalled_q <= 1'b0;
			good_q <= stalled_q ? 8'h00 : good_d;
			lock <= lock_d;
		end else begin
			if (!stall_now) begin
				per_cnt_q <= per_cnt_q + 16'h0001;
			end
			if (stall_now) begin
				// Lock kept as it was
				stalled_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Core feedback tracking
	// ----------------------------------------
	// Delay from reference edge to returned feedback edge is the tree delay
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_seen_q <= 1'b0;
			fb_dly_q <= 8'h00;
			fb_cnt_q <= 8'h00;
		end else if (in_reset) begin
			fb_seen_q <= 1'b0;
			fb_dly_q <= 8'h00;
			fb_cnt_q <= 8'h00;
		end else begin
			if (ref_edge) begin
				fb_cnt_q <= 8'h00;
			end else if (fb_cnt_q != 8'hFF) begin
				fb_cnt_q <= fb_cnt_q + 8'h01;
			end
			if (fb_edge && !fb_seen_q) begin
				fb_dly_q <= fb_cnt_q; // Feedback from loop-back
			end
			if (fb_edge) begin
				fb_seen_q <= 1'b1;
			end else if (ref_edge) begin
				fb_seen_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Output clocks
	// ----------------------------------------
	// Internal mode free-runs; local and core realign on each reference edge
	wire align = ref_edge && (fb_mode != `FB_INTERNAL);
	wire [7:0] align_val = core_fb ? fb_dly_q : 8'h00; // Advance by tree delay
	wire [2:0] outs; // Divided clocks
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_out
			out_divider u_div (
				.clk(pclk),
				.rst_n(presetn),
				.run(synth_reset_n & out_en[k]),
				.half(div_q[8*k+7:8*k]),
				.align(align),
				.align_val(align_val),
				.out_clk(outs[k])
			);
		end
	endgenerate
	assign synth_out_clk_0 = outs[0];
	assign synth_out_clk_1 = outs[1];
	assign synth_out_clk_2 = outs[2];
	wire fb_out_unused = &fb_out | ~|fb_out; // Selector kept for software only

	// ----------------------------------------
	// Reset pulse and live select watch
	// ----------------------------------------
	// Only flags a controller fault; the synthesizer still resets
	wire short_rst = synth_reset_n && !rst_prev_q &&
		(rst_len_q < `RESET_MIN_CYC);
	wire sel_live = synth_reset_n && (ref_select != sel_prev_q);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_len_q <= 4'h0;
			rst_prev_q <= 1'b1;
			sel_prev_q <= 2'h0;
		end else begin
			rst_prev_q <= synth_reset_n;
			sel_prev_q <= ref_select;
			if (synth_reset_n) begin
				rst_len_q <= 4'h0;
			end else if (rst_len_q != 4'hF) begin
				rst_len_q <= rst_len_q + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire setup = psel && !penable; // First cycle of a transfer
	wire wr_en = psel && penable && pwrite; // Write takes effect here
	wire hit = (paddr == `OFS_CTRL) || (paddr == `OFS_DIV) ||
		(paddr == `OFS_STATUS) || (paddr == `OFS_INT_STAT) ||
		(paddr == `OFS_INT_MASK) || (paddr == `OFS_LOCK_CFG);
	assign pready = 1'b1; // No wait states

	// ----------------------------------------
	// Source switch guard
	// ----------------------------------------
	// The detector still holds the old source's level for one edge after a
	// control write, so a switch could look like a reference rise
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_chg_q <= 1'b0;
		end else begin
			// Only a new source or core index can move the reference
			src_chg_q <= wr_en && (paddr == `OFS_CTRL) &&
				((pwdata[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB] != src_mode) ||
				(pwdata[`CTRL_CORE_REF_LSB+1:`CTRL_CORE_REF_LSB] != core_ref));
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	wire [`INT_W-1:0] events; // One-cycle event pulses
	assign events[`INT_LOCK_GAIN] = !in_reset && ref_edge && !lock && lock_d && !stalled_q;
	assign events[`INT_LOCK_LOSS] = !in_reset && ref_edge && lock && !lock_d && !stalled_q;
	assign events[`INT_REF_STOP] = !in_reset && !ref_edge && stall_now && !stalled_q;
	assign events[`INT_SHORT_RST] = short_rst;
	assign events[`INT_SEL_LIVE] = sel_live;
	wire [`INT_W-1:0] w1c = (wr_en && paddr == `OFS_INT_STAT) ?
		pwdata[`INT_W-1:0] : {`INT_W{1'b0}};
	// A new event beats a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_q <= {`INT_W{1'b0}};
		end else begin
			int_stat_q <= (int_stat_q & ~w1c) | events;
		end
	end
	assign irq = |(int_stat_q & int_mask_q);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RST;
			div_q <= `DIV_RST;
			int_mask_q <= `MASK_RST;
			lock_need_q <= `LOCK_CFG_RST;
		end else if (wr_en) begin
			case (paddr)
				`OFS_CTRL: ctrl_q <= pwdata & 32'h0003_3733; // Defined fields only
				`OFS_DIV: div_q <= {8'h00, pwdata[23:0]};
				`OFS_INT_MASK: int_mask_q <= pwdata[`INT_W-1:0];
				`OFS_LOCK_CFG: lock_need_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Read data and error
	// ----------------------------------------
	// Captured at setup so the access cycle returns a registered word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= !hit;
			case (paddr)
				`OFS_CTRL: prdata <= ctrl_q;
				`OFS_DIV: prdata <= div_q;
				`OFS_STATUS: prdata <= {24'h000000, fb_out_unused & 1'b0, fb_seen_q,
					stalled_q, in_reset, sel_q, ref_level, lock};
				`OFS_INT_STAT: prdata <= {27'h0000000, int_stat_q};
				`OFS_INT_MASK: prdata <= {27'h0000000, int_mask_q};
				`OFS_LOCK_CFG: prdata <= {24'h000000, lock_need_q};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Post divider lives in the configuration outside this model

endmodule // pll_fabric_interface

// ==== design/synth_map.vh ====
// Offsets, field positions, reset values and timing counts of the synthesizer wrapper.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SYNTH_MAP_VH
`define SYNTH_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_DIV 12'h004
`define OFS_STATUS 12'h008
`define OFS_INT_STAT 12'h00C
`define OFS_INT_MASK 12'h010
`define OFS_LOCK_CFG 12'h014

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_SRC_LSB 0
`define CTRL_FB_LSB 4
`define CTRL_OUT_EN_LSB 8
`define CTRL_CORE_REF_LSB 12
`define CTRL_FB_OUT_LSB 16
`define SRC_EXTERNAL 2'h0
`define SRC_DYNAMIC 2'h1
`define SRC_CORE 2'h2
`define FB_INTERNAL 2'h0
`define FB_LOCAL 2'h1
`define FB_CORE 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST 32'h0000_0710
`define DIV_RST 32'h0004_0201
`define MASK_RST 5'h00
`define LOCK_CFG_RST 8'h08

// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define INT_LOCK_GAIN 0
`define INT_LOCK_LOSS 1
`define INT_REF_STOP 2
`define INT_SHORT_RST 3
`define INT_SEL_LIVE 4
`define INT_W 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define RESET_MIN_NS 10
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STALL_CYC 1024

`endif

// ==== design/rise_detect.v ====
// Rising-edge detectors for a group of clock-like inputs.
// Assumes inputs synchronous to clk; one-cycle pulse per rising edge.
module rise_detect #(
	parameter W = 6
) (
	input wire clk, // System clock
	input wire rst_n, // Async reset, active low
	input wire [W-1:0] din, // Sampled levels
	output wire [W-1:0] rise // One-cycle pulse on rise
);

	// ----------------------------------------
	// Per-bit history
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg prev_q; // Level seen last cycle
			// Remember previous level
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					prev_q <= 1'b0;
				end else begin
					prev_q <= din[i];
				end
			end
			assign rise[i] = din[i] & ~prev_q;
		end
	endgenerate

endmodule // rise_detect

// ==== design/out_divider.v ====
// One synthesized output clock made by dividing the system clock.
// Assumes half >= 1; a zero is treated as one.
module out_divider (
	input wire clk, // System clock
	input wire rst_n, // Async reset, active low
	input wire run, // Divider allowed to toggle
	input wire [7:0] half, // Half period in cycles
	input wire align, // Phase realign pulse
	input wire [7:0] align_val, // Count preloaded at realign
	output reg out_clk // Divided clock, from a flop
);

	reg [7:0] cnt_q; // Cycles into half period
	wire [7:0] top = (half == 8'h00) ? 8'h00 : half - 8'h01; // Last count

	// ----------------------------------------
	// Counter and toggle
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			out_clk <= 1'b0;
		end else if (!run) begin
			// Held low while stopped
			cnt_q <= 8'h00;
			out_clk <= 1'b0;
		end else if (align) begin
			// Rising edge lands on the reference, advanced by align_val
			cnt_q <= (align_val > top) ? top : align_val;
			out_clk <= 1'b1;
		end else if (cnt_q >= top) begin
			cnt_q <= 8'h00;
			out_clk <= ~out_clk;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

endmodule // out_divider

// ==== verif/pll_fabric_sva.sv ====
// Checker for the synthesizer wrapper, watching top-level ports only.
// Assumes one pclk domain and presetn asynchronous, active low.
module pll_fabric_sva (
	input wire logic pclk, // System clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic [11:0] paddr, // APB address
	input wire logic pready, // APB ready
	input wire logic [31:0] prdata, // APB read data
	input wire logic pslverr, // APB error
	input wire logic [3:0] ref_clk_in, // Reference clocks
	input wire logic [1:0] ref_select, // Reference select
	input wire logic synth_reset_n, // Synth reset, active low
	input wire logic fabric_feedback_clk, // Feedback clock
	input wire logic external_ref_pin, // Dedicated reference
	input wire logic synth_out_clk_0, // Output clock 0
	input wire logic synth_out_clk_1, // Output clock 1
	input wire logic synth_out_clk_2, // Output clock 2
	input wire logic lock // Lock indicator
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Quiet counter
	// ----------------------------------------
	logic [8:0] watch_d; // Every input that may move lock
	logic [8:0] watch_q; // Last cycle's copy
	logic [2:0] quiet_q; // Calm cycles, saturates at four
	logic mapped; // Address decodes to a register
	assign watch_d = {ref_clk_in, external_ref_pin, fabric_feedback_clk, ref_select, synth_reset_n};
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
	// Bus traffic counts as a disturbance, since a write may reroute the reference
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watch_q <= 9'h000;
			quiet_q <= 3'h0;
		end else begin
			watch_q <= watch_d;
			if (watch_d != watch_q || psel) begin
				quiet_q <= 3'h0;
			end else if (quiet_q != 3'h4) begin
				quiet_q <= quiet_q + 3'h1;
			end
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_ready_high: assert property (s_access |-> pready)
		else $error("pready low in access cycle");
	a_err_unmapped: assert property (s_setup ##0 !mapped ##1 s_access |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (s_setup ##0 mapped ##1 s_access |-> !pslverr)
		else $error("mapped access refused");
	a_lock_reset_low: assert property (!synth_reset_n |=> !lock)
		else $error("lock high while synth held in reset");
	a_outs_reset_low: assert property (!synth_reset_n |=>
		!(synth_out_clk_0 || synth_out_clk_1 || synth_out_clk_2))
		else $error("output clock high while synth held in reset");
	a_lock_rise_run: assert property ($rose(lock) |->
		$past(synth_reset_n) && $past(synth_reset_n, 2))
		else $error("lock rose without running synth");
	a_lock_rise_cause: assert property ($rose(lock) |-> quiet_q < 3'h4)
		else $error("lock rose without a reference edge");
	a_lock_fall_cause: assert property ($fell(lock) |-> quiet_q < 3'h4)
		else $error("lock fell without a reference edge");
	a_lock_stall_hold: assert property (quiet_q == 3'h4 |-> $stable(lock))
		else $error("lock moved while reference stood still");
endmodule // pll_fabric_sva

bind pll_fabric_interface pll_fabric_sva pll_fabric_sva_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .ref_clk_in(ref_clk_in), .ref_select(ref_select),
	.synth_reset_n(synth_reset_n), .fabric_feedback_clk(fabric_feedback_clk),
	.external_ref_pin(external_ref_pin), .synth_out_clk_0(synth_out_clk_0),
	.synth_out_clk_1(synth_out_clk_1), .synth_out_clk_2(synth_out_clk_2), .lock(lock));

// ==== verif/fabric_partner.sv ====
// Fabric-side partner: reference clocks, select and synth reset sequencing.
// Assumes pclk from the bench; each line is divided from it in whole cycles.
module fabric_partner (
	input wire logic pclk, // System clock
	input wire logic fb_src, // Output clock to loop back
	output logic [3:0] ref_clk_in, // Reference clocks
	output logic [1:0] ref_select, // Reference select
	output logic synth_reset_n, // Synth reset, active low
	output logic fabric_feedback_clk, // Core feedback clock
	output logic external_ref_pin // Dedicated reference
);
	timeunit 1ns;
	timeprecision 1ps;
	int half [5]; // Half period per line, zero stops it
	int cnt [5]; // Cycle count within a half period
	logic fb_on; // Loop back enabled
	logic [4:0] lv_q; // Line levels
	initial begin
		half = '{default: 0};
		cnt = '{default: 0};
		fb_on = 1'b0;
		lv_q = 5'h00;
		ref_select = 2'h0;
		synth_reset_n = 1'b0;
	end
	assign ref_clk_in = lv_q[3:0];
	assign external_ref_pin = lv_q[4];
	assign fabric_feedback_clk = fb_on & fb_src;
	// A stopped line holds its level, as a discontinuous clock would
	always @(posedge pclk) begin
		for (int i = 0; i < 5; i++) begin
			if (half[i] == 0) begin
				cnt[i] <= 0;
			end else if (cnt[i] + 1 >= half[i]) begin
				lv_q[i] <= ~lv_q[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
	// Reset held one cycle plus hold; a hold of 3 keeps it low 16 ns
	task reselect(input logic [1:0] s, input int hold);
		@(posedge pclk);
		synth_reset_n <= 1'b0;
		@(posedge pclk);
		ref_select <= s;
		repeat (hold) @(posedge pclk);
		synth_reset_n <= 1'b1;
	endtask
	// Live select change, only on purpose
	task poke(input logic [1:0] s);
		@(posedge pclk);
		ref_select <= s;
	endtask
endmodule // fabric_partner

// ==== verif/test_pll_fabric_interface.sv ====
// Self-checking bench for the synthesizer wrapper over APB and fabric pins.
// Assumes synth_map.vh on the include path and the fabric partner model.
`include "synth_map.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_pll_fabric_interface;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, lock, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic o0, o1, o2, rst_n, ffc, ext;
	logic [3:0] refs;
	logic [1:0] sel;
	int miscompares, total_checks;
	pll_fabric_interface #(.STALL_CYCLES(64)) pll_fabric_interface_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.ref_clk_in(refs), .ref_select(sel), .synth_reset_n(rst_n), .fabric_feedback_clk(ffc),
		.external_ref_pin(ext), .synth_out_clk_0(o0), .synth_out_clk_1(o1),
		.synth_out_clk_2(o2), .lock(lock), .irq(irq));
	fabric_partner fabric_partner_i (.pclk(pclk), .fb_src(o0), .ref_clk_in(refs),
		.ref_select(sel), .synth_reset_n(rst_n), .fabric_feedback_clk(ffc),
		.external_ref_pin(ext));
	// ----------------------------------------
	// Bus and wait helpers
	// ----------------------------------------
	// Request held until pready is seen; #1 lets that edge's updates land
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task rdb(input logic [11:0] a, input int b, input logic e);
		apb(1'b0, a, 32'h0);
		`CHK(rd[b], e)
	endtask
	task wlock(input logic e, input int lim);
		int n;
		n = 0;
		while (lock !== e && n < lim) begin
			@(posedge pclk);
			#1;
			n++;
		end
		`CHK(lock, e)
	endtask
	task run_only(input int s);
		for (int i = 0; i < 5; i++) fabric_partner_i.half[i] = (i == s) ? 5 : 0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		logic [11:0] a [4];
		logic [31:0] e [4];
		a = '{`OFS_CTRL, `OFS_DIV, `OFS_INT_MASK, `OFS_LOCK_CFG};
		e = '{`CTRL_RST, `DIV_RST, 32'h0, 32'h0000_0008};
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, a[i], 32'h0);
			`CHK(rd, e[i])
		end
		apb(1'b0, 12'h018, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK({rd[4], rd[0]}, 2'b10)
	endtask
	// External line, local feedback: gain, interrupt, loss, regain
	task t_lock;
		run_only(4);
		fabric_partner_i.reselect(2'h0, 3);
		repeat (40) @(posedge pclk);
		`CHK(lock, 1'b0)
		wlock(1'b1, 150);
		rdb(`OFS_INT_STAT, 0, 1'b1);
		`CHK(irq, 1'b0)
		apb(1'b1, `OFS_INT_MASK, 32'h0000_001F);
		`CHK(irq, 1'b1)
		apb(1'b1, `OFS_INT_STAT, 32'h0000_001F);
		`CHK(irq, 1'b0)
		fabric_partner_i.half[4] = 7;
		wlock(1'b0, 40);
		`CHK(irq, 1'b1)
		fabric_partner_i.half[4] = 5;
		wlock(1'b1, 200);
		fabric_partner_i.half[4] = 0;
		repeat (100) @(posedge pclk);
		`CHK(lock, 1'b1)
		rdb(`OFS_INT_STAT, 2, 1'b1);
		// Reference comes back: the stale stall count must not drop lock
		fabric_partner_i.half[4] = 5;
		repeat (60) @(posedge pclk);
		`CHK(lock, 1'b1)
	endtask
	// Dynamic source over all four lines, then a refused live change
	task t_dyn;
		apb(1'b1, `OFS_CTRL, `CTRL_RST | 32'h0000_0001);
		for (int s = 0; s < 4; s++) begin
			run_only(s);
			fabric_partner_i.reselect(s[1:0], 3);
			wlock(1'b1, 200);
		end
		fabric_partner_i.reselect(2'h0, 3);
		repeat (150) @(posedge pclk);
		`CHK(lock, 1'b0)
		fabric_partner_i.reselect(2'h3, 3);
		wlock(1'b1, 200);
		fabric_partner_i.half[0] = 7;
		fabric_partner_i.poke(2'h0);
		repeat (60) @(posedge pclk);
		`CHK(lock, 1'b1)
		rdb(`OFS_INT_STAT, 4, 1'b1);
	endtask
	// Core source on line 2 with output 0 looped back
	task t_core;
		logic [2:0] seen, pv;
		run_only(2);
		@(posedge pclk);
		fabric_partner_i.fb_on <= 1'b1;
		// Three outputs on, so the post divider is taken as two or more
		apb(1'b1, `OFS_CTRL, 32'h0000_2722);
		fabric_partner_i.reselect(2'h0, 3);
		wlock(1'b1, 200);
		seen = 3'h0;
		pv = {o2, o1, o0};
		repeat (40) begin
			@(posedge pclk);
			#1;
			seen |= pv ^ {o2, o1, o0};
			pv = {o2, o1, o0};
		end
		`CHK(seen, 3'h7)
		@(posedge pclk);
		fabric_partner_i.fb_on <= 1'b0;
		fabric_partner_i.reselect(2'h0, 3);
		repeat (150) @(posedge pclk);
		`CHK(lock, 1'b0)
	endtask
	// Reset pulse of 8 ns is flagged, 12 ns is not
	task t_short;
		apb(1'b1, `OFS_INT_STAT, 32'h0000_001F);
		fabric_partner_i.reselect(2'h0, 1);
		repeat (3) @(posedge pclk);
		rdb(`OFS_INT_STAT, 3, 1'b1);
		apb(1'b1, `OFS_INT_STAT, 32'h0000_001F);
		fabric_partner_i.reselect(2'h0, 2);
		repeat (3) @(posedge pclk);
		rdb(`OFS_INT_STAT, 3, 1'b0);
	endtask
	task stop_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, main sequence, watchdog
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_lock;
		t_dyn;
		t_core;
		t_short;
		stop_test;
	end
	// Whole run needs about 1500 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		stop_test;
	end
endmodule // test_pll_fabric_interface
